//--- inc/wakeup_map.vh
`ifndef WAKEUP_MAP_VH
`define WAKEUP_MAP_VH
// register byte offsets
`define OFS_WAKE_EN     8'h00
`define OFS_IRQ_EN      8'h04
`define OFS_CTRL        8'h08
`define OFS_STATUS      8'h0C
`define OFS_MASK        8'h10
`define OFS_RESULT      8'h14
`define OFS_VEC_EXT     8'h18
`define OFS_VEC_PORT    8'h1C
`define OFS_VEC_TMR     8'h20
`define OFS_VEC_SER     8'h24
// source bit positions
`define SRC_EXT         0
`define SRC_PORT        1
`define SRC_TMR         2
`define SRC_SER         3
`define NSRC            4
// ctrl register fields
`define CTRL_GIE        0
`define CTRL_MODE_LO    1
`define CTRL_MODE_HI    2
`define CTRL_SLAVE      3
// power modes
`define MODE_SLEEP      2'h0
`define MODE_IDLE       2'h1
`define MODE_GREEN      2'h2
`define MODE_NORMAL     2'h3
// status bits
`define ST_WAKE         0
`define ST_VECTOR       1
`define ST_INVALID      2
// reset values
`define RST_CTRL        4'h6
`define RST_VEC_EXT     8'h03
`define RST_VEC_PORT    8'h06
`define RST_VEC_TMR     8'h09
`define RST_VEC_SER     8'h0C
`endif

//--- hdl/wake_decide.v
`timescale 1ns/1ps
`include "wakeup_map.vh"
// per-source decision for one event
module wake_decide (
    input  wire [1:0] mode,
    input  wire       gie,
    input  wire       irq_en,
    input  wire       wake_ok_sleep,
    input  wire       wake_ok_idle,
    output reg        act_wake,
    output reg        act_vector,
    output reg        act_next,
    output reg        act_invalid
);
    reg low_power;
    reg can_wake;
    always @* begin
        low_power = (mode == `MODE_SLEEP) || (mode == `MODE_IDLE);
        can_wake = (mode == `MODE_SLEEP) ? wake_ok_sleep : wake_ok_idle;
        act_wake = 1'b0;
        act_vector = 1'b0;
        act_next = 1'b0;
        act_invalid = 1'b0;
        if (low_power) begin
            if (can_wake) begin
                act_wake = 1'b1;
                act_vector = gie & irq_en;
                act_next = ~(gie & irq_en);
            end else begin
                act_invalid = 1'b1;
            end
        end else if (irq_en) begin
            act_vector = gie;
            act_next = ~gie;
        end else begin
            act_invalid = 1'b1;
        end
    end
endmodule

//--- hdl/wakeup_interrupt_dispatch.v
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "wakeup_map.vh"
module wakeup_interrupt_dispatch (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        ext_pin_evt,
    input  wire        port_change_evt,
    input  wire        timer_overflow_evt,
    input  wire        serial_if_evt,
    input  wire        sleep_instruction,
    input  wire        global_irq_enable,
    input  wire        global_irq_disable,
    output reg         wake_pulse,
    output reg         vector_take,
    output reg         next_resume,
    output reg  [7:0]  vector_addr,
    output wire        irq
);
    localparam ST_RUN = 2'b01;
    localparam ST_LOW = 2'b10;

    reg [`NSRC-1:0] wake_en_r;
    reg [`NSRC-1:0] irq_en_r;
    reg             gie_r;
    reg [1:0]       mode_r;
    reg             slave_r;
    reg [2:0]       status_r;
    reg [2:0]       mask_r;
    reg [7:0]       result_r;
    reg [7:0]       vec_r [0:`NSRC-1];
    reg [1:0]       state_r;
    reg [1:0]       run_mode_r;
    reg [31:0]      rdata_r;
    reg             wr_pend_r;
    reg [7:0]       wr_addr_r;

    wire [`NSRC-1:0] evt = {serial_if_evt, timer_overflow_evt, port_change_evt, ext_pin_evt};
    wire [`NSRC-1:0] ok_sleep;
    wire [`NSRC-1:0] ok_idle;
    wire [`NSRC-1:0] a_wake;
    wire [`NSRC-1:0] a_vec;
    wire [`NSRC-1:0] a_next;
    wire [`NSRC-1:0] a_inv;

    assign ok_sleep[`SRC_EXT]  = wake_en_r[`SRC_EXT];
    assign ok_idle[`SRC_EXT]   = wake_en_r[`SRC_EXT];
    assign ok_sleep[`SRC_PORT] = wake_en_r[`SRC_PORT];
    assign ok_idle[`SRC_PORT]  = wake_en_r[`SRC_PORT];
    assign ok_sleep[`SRC_TMR]  = 1'b0;
    assign ok_idle[`SRC_TMR]   = irq_en_r[`SRC_TMR];
    assign ok_sleep[`SRC_SER]  = wake_en_r[`SRC_SER] & slave_r;
    assign ok_idle[`SRC_SER]   = wake_en_r[`SRC_SER] & slave_r;

    genvar g;
    generate
        for (g = 0; g < `NSRC; g = g + 1) begin : src
            wake_decide u_dec (
                .mode          (mode_r),
                .gie           (gie_r),
                .irq_en        (irq_en_r[g]),
                .wake_ok_sleep (ok_sleep[g]),
                .wake_ok_idle  (ok_idle[g]),
                .act_wake      (a_wake[g]),
                .act_vector    (a_vec[g]),
                .act_next      (a_next[g]),
                .act_invalid   (a_inv[g])
            );
        end
    endgenerate

    // lowest-numbered firing source whose action is not invalid wins
    reg       hit;
    reg [1:0] win;
    integer   i;
    always @* begin
        hit = 1'b0;
        win = 2'h0;
        for (i = `NSRC - 1; i >= 0; i = i - 1) begin
            if (evt[i] && !a_inv[i]) begin
                hit = 1'b1;
                win = i[1:0];
            end
        end
    end

    wire in_low   = (state_r == ST_LOW);
    wire any_inv  = |(evt & a_inv);
    wire do_wake  = in_low & hit & a_wake[win];
    wire do_run   = ~in_low & hit;
    wire fire     = do_wake | do_run;

    // bus
    wire        acc    = hsel & hready & htrans[1];
    wire [31:0] wdat   = hwdata;
    wire        wr_now = wr_pend_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    wire [2:0] ev_bits = {any_inv, fire & a_vec[win], do_wake};

    always @(posedge clk) begin
        if (!rst_b) begin
            wake_en_r  <= {`NSRC{1'b0}};
            irq_en_r   <= {`NSRC{1'b0}};
            gie_r      <= 1'b0;
            mode_r     <= `MODE_NORMAL;
            run_mode_r <= `MODE_NORMAL;
            slave_r    <= 1'b0;
            status_r   <= 3'h0;
            mask_r     <= 3'h0;
            result_r   <= 8'h00;
            vec_r[`SRC_EXT]  <= `RST_VEC_EXT;
            vec_r[`SRC_PORT] <= `RST_VEC_PORT;
            vec_r[`SRC_TMR]  <= `RST_VEC_TMR;
            vec_r[`SRC_SER]  <= `RST_VEC_SER;
            state_r    <= ST_RUN;
            rdata_r    <= 32'h00000000;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            wake_pulse <= 1'b0;
            vector_take <= 1'b0;
            next_resume <= 1'b0;
            vector_addr <= 8'h00;
        end else begin
            wr_pend_r <= acc & hwrite;
            wr_addr_r <= haddr;
            if (global_irq_enable)
                gie_r <= 1'b1;
            else if (global_irq_disable)
                gie_r <= 1'b0;
            if (wr_now) begin
                case (wr_addr_r)
                    `OFS_WAKE_EN: wake_en_r <= wdat[`NSRC-1:0];
                    `OFS_IRQ_EN:  irq_en_r <= wdat[`NSRC-1:0];
                    `OFS_CTRL: begin
                        if (!global_irq_enable && !global_irq_disable)
                            gie_r <= wdat[`CTRL_GIE];
                        run_mode_r <= wdat[`CTRL_MODE_HI:`CTRL_MODE_LO];
                        if (!in_low)
                            mode_r <= wdat[`CTRL_MODE_HI:`CTRL_MODE_LO];
                        slave_r <= wdat[`CTRL_SLAVE];
                    end
                    `OFS_MASK:     mask_r <= wdat[2:0];
                    `OFS_VEC_EXT:  vec_r[`SRC_EXT] <= wdat[7:0];
                    `OFS_VEC_PORT: vec_r[`SRC_PORT] <= wdat[7:0];
                    `OFS_VEC_TMR:  vec_r[`SRC_TMR] <= wdat[7:0];
                    `OFS_VEC_SER:  vec_r[`SRC_SER] <= wdat[7:0];
                    default: ;
                endcase
            end
            // set beats write-one-to-clear
            status_r <= (status_r & ~((wr_now && wr_addr_r == `OFS_STATUS) ? wdat[2:0] : 3'h0)) | ev_bits;
            case (state_r)
                ST_RUN: begin
                    if (sleep_instruction && (mode_r == `MODE_SLEEP || mode_r == `MODE_IDLE))
                        state_r <= ST_LOW;
                end
                ST_LOW: begin
                    if (do_wake) begin
                        state_r <= ST_RUN;
                        mode_r  <= (run_mode_r == `MODE_SLEEP || run_mode_r == `MODE_IDLE) ?
                                   `MODE_NORMAL : run_mode_r;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
            wake_pulse  <= do_wake;
            vector_take <= fire & a_vec[win];
            next_resume <= fire & a_next[win];
            if (fire) begin
                vector_addr <= a_vec[win] ? vec_r[win] : 8'h00;
                result_r    <= {2'h0, win, 1'b0, a_vec[win], a_next[win], do_wake};
            end
            if (acc && !hwrite) begin
                case (haddr)
                    `OFS_WAKE_EN:  rdata_r <= {28'h0000000, wake_en_r};
                    `OFS_IRQ_EN:   rdata_r <= {28'h0000000, irq_en_r};
                    `OFS_CTRL:     rdata_r <= {28'h0000000, slave_r, mode_r, gie_r};
                    `OFS_STATUS:   rdata_r <= {29'h00000000, status_r};
                    `OFS_MASK:     rdata_r <= {29'h00000000, mask_r};
                    `OFS_RESULT:   rdata_r <= {24'h000000, result_r};
                    `OFS_VEC_EXT:  rdata_r <= {24'h000000, vec_r[`SRC_EXT]};
                    `OFS_VEC_PORT: rdata_r <= {24'h000000, vec_r[`SRC_PORT]};
                    `OFS_VEC_TMR:  rdata_r <= {24'h000000, vec_r[`SRC_TMR]};
                    `OFS_VEC_SER:  rdata_r <= {24'h000000, vec_r[`SRC_SER]};
                    default:       rdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    assign irq = |(status_r & mask_r);
endmodule

//--- verification/wake_monitor.sv
`timescale 1ns/1ps
`include "wakeup_map.vh"
module wake_monitor (
    input wire       clk,
    input wire       rst_b,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       hreadyout,
    input wire       hresp,
    input wire       ext_pin_evt,
    input wire       port_change_evt,
    input wire       timer_overflow_evt,
    input wire       serial_if_evt,
    input wire       wake_pulse,
    input wire       vector_take,
    input wire       next_resume,
    input wire [7:0] vector_addr,
    input wire       irq
);
    wire evt = ext_pin_evt | port_change_evt | timer_overflow_evt | serial_if_evt;
    wire act = wake_pulse | vector_take | next_resume;
    reg  wr_d1;
    reg  wr_d2;
    always @(posedge clk) begin
        wr_d1 <= hsel & hready & htrans[1] & hwrite;
        wr_d2 <= wr_d1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_act_has_cause: assert property (act |-> $past(evt))
        else $error("action without a source event");
    a_one_resume: assert property (!(vector_take && next_resume))
        else $error("vector and next instruction together");
    a_wake_resumes: assert property (wake_pulse |-> (vector_take || next_resume))
        else $error("wake without resume action");
    a_next_no_addr: assert property (next_resume |-> vector_addr == 8'h00)
        else $error("next instruction with vector address");
    a_vector_table: assert property (vector_take |-> vector_addr inside {`RST_VEC_EXT, `RST_VEC_PORT,
        `RST_VEC_TMR, `RST_VEC_SER})
        else $error("vector address outside table");
    a_addr_holds: assert property (!$stable(vector_addr) |-> (vector_take || next_resume))
        else $error("vector address moved without action");
    a_irq_cause: assert property ($rose(irq) |-> $past(evt) || $past(evt, 2) || wr_d1 || wr_d2)
        else $error("interrupt rose without cause");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
    c_wake_vec: cover property (wake_pulse && vector_take);
    c_wake_next: cover property (wake_pulse && next_resume);
    c_run_vec: cover property (vector_take && !wake_pulse);
    c_irq: cover property ($rose(irq));
endmodule
bind wakeup_interrupt_dispatch wake_monitor wake_monitor_inst (.clk, .rst_b, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .ext_pin_evt, .port_change_evt, .timer_overflow_evt, .serial_if_evt,
    .wake_pulse, .vector_take, .next_resume, .vector_addr, .irq);

//--- verification/core_src_model.sv
`timescale 1ns/1ps
module core_src_model (
    input  wire clk,
    output wire ext_pin_evt,
    output wire port_change_evt,
    output wire timer_overflow_evt,
    output wire serial_if_evt,
    output wire sleep_instruction,
    output wire global_irq_enable,
    output wire global_irq_disable
);
    reg [6:0] v = 7'h00;
    assign {global_irq_disable, global_irq_enable, sleep_instruction, serial_if_evt,
        timer_overflow_evt, port_change_evt, ext_pin_evt} = v;
    // one source or one core action per call, each a single-cycle pulse
    task pulse(input [6:0] b);
        begin
            @(posedge clk);
            v <= b;
            @(posedge clk);
            v <= 7'h00;
        end
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
`include "wakeup_map.vh"
module tb;
    reg         clk;
    reg         rst_b;
    reg         hsel;
    reg  [7:0]  haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [31:0] hwdata;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, irq;
    wire        ext_pin_evt, port_change_evt, timer_overflow_evt, serial_if_evt;
    wire        sleep_instruction, global_irq_enable, global_irq_disable;
    wire        wake_pulse, vector_take, next_resume;
    wire [7:0]  vector_addr;
    integer     fails, checked, cyc, seed, k;
    reg  [11:0] expq[$];
    reg  [11:0] e;
    reg  [31:0] rd;
    wakeup_interrupt_dispatch wakeup_interrupt_dispatch_inst (.clk, .rst_b, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin_evt,
        .port_change_evt, .timer_overflow_evt, .serial_if_evt, .sleep_instruction, .global_irq_enable,
        .global_irq_disable, .wake_pulse, .vector_take, .next_resume, .vector_addr, .irq);
    core_src_model core_src_model_inst (.clk, .ext_pin_evt, .port_change_evt, .timer_overflow_evt,
        .serial_if_evt, .sleep_instruction, .global_irq_enable, .global_irq_disable);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task final_report;
        begin
            if (fails == 0 && checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] ex, input [31:0] sn);
        begin
            checked = checked + 1;
            if (sn !== ex) begin
                fails = fails + 1;
                $display("BAD %0s exp %h seen %h", n, ex, sn);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    // {acts, wake, vector, next, addr} predicted from source, mode and enables
    function [11:0] outcome(input [1:0] s, input [1:0] m, input g, input we, input ie, input sl);
        reg wk;
        reg act;
        begin
            wk = (m < 2'h2) && (s == 2'h2 ? ie && m == 2'h1 : s == 2'h3 ? we && sl : we);
            act = (m < 2'h2) ? wk : ie;
            outcome = {act, wk, act & g & ie, act & ~(g & ie),
                (act & g & ie) ? (s == 2'h0 ? `RST_VEC_EXT : s == 2'h1 ? `RST_VEC_PORT :
                s == 2'h2 ? `RST_VEC_TMR : `RST_VEC_SER) : 8'h00};
        end
    endfunction
    task run_case(input [1:0] s, input [1:0] m, input g, input we, input ie);
        reg        sl;
        reg [31:0] rnd;
        begin
            rnd = $random(seed);
            sl = rnd[0];
            bus(1'b1, `OFS_WAKE_EN, (32'h1 << s) & {32{we}});
            bus(1'b1, `OFS_IRQ_EN, (32'h1 << s) & {32{ie}});
            bus(1'b1, `OFS_CTRL, {28'h0, sl, m, 1'b0});
            core_src_model_inst.pulse(g ? 7'h20 : 7'h40);
            if (m < 2'h2) core_src_model_inst.pulse(7'h10);
            e = outcome(s, m, g, we, ie, sl);
            if (e[11]) expq.push_back(e);
            core_src_model_inst.pulse(7'h01 << s);
            repeat (4) @(posedge clk);
            if (m < 2'h2 && !e[10]) begin
                bus(1'b1, `OFS_WAKE_EN, 32'h1);
                expq.push_back(outcome(2'h0, m, g, 1'b1, ie && s == 2'h0, sl));
                core_src_model_inst.pulse(7'h01);
                repeat (4) @(posedge clk);
            end
        end
    endtask
    task irq_chk(input ex);
        begin
            repeat (2) @(posedge clk);
            chk("irq", {31'h0, ex}, {31'h0, irq});
        end
    endtask
    always @(posedge clk) begin
        if (rst_b === 1'b1 && (wake_pulse | vector_take | next_resume) === 1'b1) begin
            if (expq.size() == 0) chk("unexpected action", 32'h0, 32'h1);
            else chk("action", {20'h0, expq.pop_front() & 12'h7FF},
                {21'h0, wake_pulse, vector_take, next_resume, vector_addr});
        end
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            final_report;
        end
    end
    initial begin
        seed = 87022;
        fails = 0;
        checked = 0;
        cyc = 0;
        {rst_b, hsel, haddr, htrans, hwrite, hwdata} = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl reset", {28'h0, `RST_CTRL}, rd);
        bus(1'b0, `OFS_VEC_PORT, 32'h0);
        chk("vector reset", {24'h0, `RST_VEC_PORT}, rd);
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped read", 32'h0, rd);
        for (k = 0; k < 128; k = k + 1) run_case(k[1:0], k[3:2], k[4], k[5], k[6]);
        bus(1'b1, `OFS_MASK, 32'h0);
        irq_chk(1'b0);
        bus(1'b1, `OFS_STATUS, 32'h7);
        run_case(2'h1, `MODE_NORMAL, 1'b1, 1'b0, 1'b1);
        bus(1'b1, `OFS_MASK, 32'h2);
        irq_chk(1'b1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        bus(1'b1, `OFS_STATUS, 32'h2);
        irq_chk(1'b0);
        // timer with irq enable off in green mode only flags invalid
        run_case(2'h2, `MODE_GREEN, 1'b1, 1'b0, 1'b0);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("invalid flag", 32'h1 << `ST_INVALID, rd);
        bus(1'b1, `OFS_STATUS, 32'h7);
        // pin wake from sleep with interrupts disabled resumes at next instruction
        run_case(2'h0, `MODE_SLEEP, 1'b0, 1'b1, 1'b0);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("wake flag", 32'h1 << `ST_WAKE, rd);
        bus(1'b0, `OFS_RESULT, 32'h0);
        chk("result", 32'h3, rd);
        chk("pending", 32'h0, expq.size());
        final_report;
    end
endmodule
